// *** rtl/ccio_pkg.sv ***
package ccio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int WORD_W = 48;
  localparam int CHAR_W = 6;
  localparam int TAPE_W = 8;
  localparam int KBD_W = 6;
  localparam int LEVEL7_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // avalon register byte offsets
  localparam logic [4:0] OFS_FUNC = 5'h00;
  localparam logic [4:0] OFS_SENSE = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_IN_LO = 5'h0c;
  localparam logic [4:0] OFS_IN_HI = 5'h10;
  localparam logic [4:0] OFS_OUT_LO = 5'h14;
  localparam logic [4:0] OFS_OUT_HI = 5'h18;
  localparam logic [4:0] OFS_BUF = 5'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // buffer control fields
  localparam int BUF_IN_ACT = 0;
  localparam int BUF_OUT_ACT = 1;
  localparam int BUF_EIGHT = 2;

  // status fields
  localparam int ST_SEL_RDR = 0;
  localparam int ST_SEL_PUN = 1;
  localparam int ST_SEL_KBD = 2;
  localparam int ST_SEL_PRT = 3;
  localparam int ST_CR_IRQ = 4;
  localparam int ST_TAPE_END = 5;
  localparam int ST_EOT_IRQ = 6;
  localparam int ST_PACK = 7;
  localparam int ST_PUN_MOT = 8;
  localparam int ST_RDR_MOT = 9;
  localparam int ST_CLUTCH = 10;
  localparam int ST_IN_RDY = 11;
  localparam int ST_OUT_RDY = 12;
  localparam int ST_ASM_CNT = 13;
  localparam int ST_DIS_CNT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // function code octal digits: channel, equipment, modifier
  localparam logic [2:0] CH_IN = 3'h1;
  localparam logic [2:0] CH_OUT = 3'h2;
  localparam logic [5:0] EQ_TYPE = 6'h09;
  localparam logic [5:0] EQ_TAPE = 6'h0a;
  localparam logic [2:0] D1_ZERO = 3'h0;
  localparam logic [2:0] D1_EOT_SET = 3'h1;
  localparam logic [2:0] D1_NO_EOT = 3'h2;
  localparam logic [2:0] D1_CR_IRQ = 3'h4;
  localparam logic [2:0] D1_MOTOR_MAX = 3'h3;
  localparam logic [2:0] D1_MOTOR_OFF = 3'h4;

  // sense codes, bit 0 ignored
  localparam logic [14:0] SNS_KBD_CR = 15'h1240;
  localparam logic [14:0] SNS_KBD_CASE = 15'h1260;
  localparam logic [14:0] SNS_RDR_EOT = 15'h1280;
  localparam logic [14:0] SNS_RDR_MODE = 15'h1288;
  localparam logic [14:0] SNS_PUN_OUT = 15'h2280;

  ////////////////////////////////////////////////////////////////////////////
  // counter positions and reset values
  localparam logic [2:0] CNT_CHAR7 = 3'h0;
  localparam logic [2:0] CNT_CHAR0 = 3'h7;
  localparam logic RST_SEL_RDR = 1'b1;
  localparam logic RST_WREQ = 1'b1;

endpackage : ccio_pkg

// *** rtl/ccio_cnt_if.sv ***
`timescale 1ns/10ps
interface ccio_cnt_if;
  logic init7;
  logic force0;
  logic adv;
  logic [2:0] cnt;
  modport ctl (output init7, output force0, output adv, input cnt);
  modport cnt_side (input init7, input force0, input adv, output cnt);
endinterface : ccio_cnt_if

// *** rtl/ccio_char_cnt.sv ***
`timescale 1ns/10ps
module ccio_char_cnt import ccio_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // counter control
  ccio_cnt_if.cnt_side ctl_if
);

  typedef struct packed {
    logic [2:0] cnt;
  } ccio_cnt_st_t;

  ccio_cnt_st_t st_r;
  ccio_cnt_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ctl_if.init7) begin
      st_nxt.cnt = CNT_CHAR7;
    end else if (ctl_if.force0) begin
      st_nxt.cnt = CNT_CHAR0;
    end else if (ctl_if.adv) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r.cnt <= CNT_CHAR7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl_if.cnt = st_r.cnt;

endmodule : ccio_char_cnt

// *** rtl/ccio_top.sv ***
// Contract
// - character mode: low bits, zeros above
// - assembly word is eight six-bit characters
// - assemble eight characters from char 7, then send
// - split word, emit char 7 down to 0
// - code 15 bits, top 3 pick channel
// - recognise reader, punch, keyboard, printer codes
// - four selection flags set on function strobe
// - selecting one clears other on channel
// - master clear selects the reader
// - reader codes: eot irq, set eot, none
// - keyboard codes: carriage return irq off/on
// - channel two mode and motor off codes
// - select codes update auxiliary flags
// - sense ignores low bit, returns one
// - five sense conditions reported
// - assembly counter steers and advances per character
// - reader character mode forces character 0
// - keyboard six bits to low stages, zeros
// - register cleared when no input selected
// - disassembly counter advances or forced char 0
// - ready after word or each character
// - tape stops on inactive or missing level 7 at word start (char 7)
// - tape end clears on select, sets on cases
// - resume clears register and ready
`timescale 1ns/10ps
module ccio_top import ccio_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // avalon slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // tape reader
  input wire logic [7:0] rdr_char_in,
  input wire logic rdr_feed_in,
  input wire logic reader_mode_sw_in,
  input wire logic reader_motor_sw_in,
  output logic reader_clutch_out,
  output logic reader_motor_out,
  // keyboard
  input wire logic [5:0] kbd_char_in,
  input wire logic kbd_strobe_in,
  input wire logic kbd_cr_tab_in,
  input wire logic kbd_upper_case_in,
  // punch and printer
  input wire logic out_timing_in,
  input wire logic punch_out_of_tape_in,
  output logic [7:0] out_char_out,
  output logic punch_strobe_out,
  output logic print_strobe_out,
  output logic punch_motor_out,
  // external master clear
  input wire logic ext_master_clear_in
);

  ////////////////////////////////////////////////////////////////////////////
  // types and state

  typedef struct packed {
    logic [7:0] rchar;
    logic [5:0] kchar;
    logic feed;
    logic kstb;
    logic tim;
    logic rmode;
    logic rmot;
    logic cr_tab;
    logic upper;
    logic pun_out;
    logic mclr;
  } ccio_pins_t;

  typedef struct packed {
    ccio_pins_t s1;
    ccio_pins_t s2;
    logic feed_d;
    logic kstb_d;
    logic tim_d;
    logic reader_selected_flag;
    logic punch_selected_flag;
    logic keyboard_selected_flag;
    logic printer_selected_flag;
    logic line_return_irq_enable;
    logic tape_end_flag;
    logic tape_end_irq_enable;
    logic six_bit_packing_flag;
    logic punch_motor_flag;
    logic reader_motor_flag;
    logic sense_return_gate;
    logic in_active;
    logic in_active_d;
    logic out_active;
    logic out_active_d;
    logic eight_level;
    logic clutch;
    logic in_ready;
    logic out_ready;
    logic [WORD_W-1:0] input_assembly_register;
    logic [WORD_W-1:0] output_word_register;
    logic [7:0] out_char;
    logic punch_stb;
    logic print_stb;
    logic wreq;
    logic [31:0] rdata;
  } ccio_st_t;

  ccio_st_t st_r;
  ccio_st_t st_nxt;
  ccio_pins_t pins;
  ccio_cnt_if asm_if ();
  ccio_cnt_if dis_if ();

  logic bus_acc;
  logic in_start;
  logic out_start;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] be_mask(input logic [31:0] d, input logic [3:0] be);
    be_mask = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic sense_eval(input logic [14:0] code, input ccio_st_t s);
    logic [14:0] c;
    c = {code[14:1], 1'b0};
    if (c == SNS_KBD_CR) begin
      sense_eval = s.s2.cr_tab;
    end else if (c == SNS_KBD_CASE) begin
      sense_eval = ~s.s2.upper;
    end else if (c == SNS_RDR_EOT) begin
      sense_eval = s.tape_end_flag;
    end else if (c == SNS_RDR_MODE) begin
      sense_eval = s.s2.rmode;
    end else if (c == SNS_PUN_OUT) begin
      sense_eval = s.s2.pun_out;
    end else begin
      sense_eval = 1'b0;
    end
  endfunction : sense_eval

  function automatic logic [31:0] status_word(input ccio_st_t s, input logic [2:0] ac,
                                              input logic [2:0] dc);
    status_word = '0;
    status_word[ST_SEL_RDR] = s.reader_selected_flag;
    status_word[ST_SEL_PUN] = s.punch_selected_flag;
    status_word[ST_SEL_KBD] = s.keyboard_selected_flag;
    status_word[ST_SEL_PRT] = s.printer_selected_flag;
    status_word[ST_CR_IRQ] = s.line_return_irq_enable;
    status_word[ST_TAPE_END] = s.tape_end_flag;
    status_word[ST_EOT_IRQ] = s.tape_end_irq_enable;
    status_word[ST_PACK] = s.six_bit_packing_flag;
    status_word[ST_PUN_MOT] = s.punch_motor_flag;
    status_word[ST_RDR_MOT] = s.reader_motor_flag;
    status_word[ST_CLUTCH] = s.clutch;
    status_word[ST_IN_RDY] = s.in_ready;
    status_word[ST_OUT_RDY] = s.out_ready;
    status_word[ST_ASM_CNT +: 3] = ac;
    status_word[ST_DIS_CNT +: 3] = dc;
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////
  // counters

  assign pins = '{rchar: rdr_char_in, kchar: kbd_char_in, feed: rdr_feed_in,
                  kstb: kbd_strobe_in, tim: out_timing_in, rmode: reader_mode_sw_in,
                  rmot: reader_motor_sw_in, cr_tab: kbd_cr_tab_in,
                  upper: kbd_upper_case_in, pun_out: punch_out_of_tape_in,
                  mclr: ext_master_clear_in};

  assign bus_acc = (avs_read_in | avs_write_in) & ~st_r.wreq;
  assign in_start = st_r.in_active & ~st_r.in_active_d;
  assign out_start = st_r.out_active & ~st_r.out_active_d;

  assign asm_if.init7 = ~st_r.in_active | in_start;
  assign asm_if.force0 = ~st_r.s2.rmode;
  assign dis_if.init7 = ~st_r.out_active | out_start;
  assign dis_if.force0 = ~st_r.six_bit_packing_flag;

  ccio_char_cnt u_asm_cnt (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ctl_if(asm_if.cnt_side)
  );

  ccio_char_cnt u_dis_cnt (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ctl_if(dis_if.cnt_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [14:0] fc;
    logic [2:0] ch;
    logic [5:0] eq;
    logic [2:0] d1;
    logic [2:0] aidx;
    logic [2:0] didx;
    logic [7:0] rch;
    logic feed_rise;
    logic kbd_rise;
    logic tim_rise;
    logic [31:0] lane_m;
    lane_m = be_mask('1, avs_byteenable_in);
    fc = avs_writedata_in[14:0] & lane_m[14:0];
    ch = fc[14:12];
    eq = fc[11:6];
    d1 = fc[5:3];
    aidx = ~asm_if.cnt;
    didx = ~dis_if.cnt;
    rch = st_r.s2.rchar;
    feed_rise = st_r.s2.feed & ~st_r.feed_d;
    kbd_rise = st_r.s2.kstb & ~st_r.kstb_d;
    tim_rise = st_r.s2.tim & ~st_r.tim_d;
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.feed_d = st_r.s2.feed;
    st_nxt.kstb_d = st_r.s2.kstb;
    st_nxt.tim_d = st_r.s2.tim;
    st_nxt.in_active_d = st_r.in_active;
    st_nxt.out_active_d = st_r.out_active;
    st_nxt.reader_motor_flag = st_r.s2.rmot;
    st_nxt.punch_stb = 1'b0;
    st_nxt.print_stb = 1'b0;
    asm_if.adv = 1'b0;
    dis_if.adv = 1'b0;

    // bus handshake: one wait cycle, then accept
    st_nxt.wreq = ~((avs_read_in | avs_write_in) & st_r.wreq);
    if ((avs_read_in | avs_write_in) & st_r.wreq) begin
      st_nxt.rdata = '0;
      if (avs_address_in == OFS_SENSE) begin
        st_nxt.rdata[0] = st_r.sense_return_gate;
      end else if (avs_address_in == OFS_STATUS) begin
        st_nxt.rdata = status_word(st_r, asm_if.cnt, dis_if.cnt);
      end else if (avs_address_in == OFS_IN_LO) begin
        st_nxt.rdata = st_r.input_assembly_register[31:0];
      end else if (avs_address_in == OFS_IN_HI) begin
        st_nxt.rdata[15:0] = st_r.input_assembly_register[47:32];
      end else if (avs_address_in == OFS_OUT_LO) begin
        st_nxt.rdata = st_r.output_word_register[31:0];
      end else if (avs_address_in == OFS_OUT_HI) begin
        st_nxt.rdata[15:0] = st_r.output_word_register[47:32];
      end else if (avs_address_in == OFS_BUF) begin
        st_nxt.rdata[BUF_IN_ACT] = st_r.in_active;
        st_nxt.rdata[BUF_OUT_ACT] = st_r.out_active;
        st_nxt.rdata[BUF_EIGHT] = st_r.eight_level;
      end
    end

    // select codes on the function strobe
    if (bus_acc & avs_write_in & (avs_address_in == OFS_FUNC)) begin
      if ((ch == CH_IN) | (ch == CH_OUT)) begin
        st_nxt.tape_end_flag = 1'b0;
      end
      if ((ch == CH_IN) & (eq == EQ_TAPE)) begin
        st_nxt.reader_selected_flag = 1'b1;
        st_nxt.keyboard_selected_flag = 1'b0;
        if (d1 == D1_ZERO) begin
          st_nxt.tape_end_irq_enable = 1'b1;
        end else if (d1 == D1_EOT_SET) begin
          st_nxt.tape_end_flag = 1'b1;
        end else if (d1 == D1_NO_EOT) begin
          st_nxt.tape_end_irq_enable = 1'b0;
        end
      end else if ((ch == CH_IN) & (eq == EQ_TYPE)) begin
        st_nxt.keyboard_selected_flag = 1'b1;
        st_nxt.reader_selected_flag = 1'b0;
        st_nxt.line_return_irq_enable = (d1 == D1_CR_IRQ);
      end else if ((ch == CH_OUT) & (eq == EQ_TYPE)) begin
        st_nxt.printer_selected_flag = 1'b1;
        st_nxt.punch_selected_flag = 1'b0;
        st_nxt.six_bit_packing_flag = (d1 == D1_ZERO);
      end else if ((ch == CH_OUT) & (eq == EQ_TAPE)) begin
        if (d1 == D1_MOTOR_OFF) begin
          st_nxt.punch_motor_flag = 1'b0;
        end else if (d1 <= D1_MOTOR_MAX) begin
          st_nxt.punch_selected_flag = 1'b1;
          st_nxt.printer_selected_flag = 1'b0;
          st_nxt.punch_motor_flag = 1'b1;
          st_nxt.six_bit_packing_flag = (d1 == D1_ZERO);
        end
      end
    end

    // sense codes
    if (bus_acc & avs_write_in & (avs_address_in == OFS_SENSE)) begin
      st_nxt.sense_return_gate = sense_eval(fc, st_r);
    end

    // buffer control register write
    if (bus_acc & avs_write_in & (avs_address_in == OFS_BUF) & avs_byteenable_in[0]) begin
      st_nxt.in_active = avs_writedata_in[BUF_IN_ACT];
      st_nxt.out_active = avs_writedata_in[BUF_OUT_ACT];
      st_nxt.eight_level = avs_writedata_in[BUF_EIGHT];
    end

    // reader clutch
    if (in_start & st_r.reader_selected_flag) begin
      st_nxt.clutch = 1'b1;
    end
    if (~st_r.in_active) begin
      st_nxt.clutch = 1'b0;
    end

    // resume from the computer
    if (bus_acc & avs_read_in & (avs_address_in == OFS_IN_HI)) begin
      st_nxt.input_assembly_register = '0;
      st_nxt.in_ready = 1'b0;
    end

    // reader feed
    if (feed_rise & st_r.clutch & st_r.reader_selected_flag & ~st_r.in_ready) begin
      if (st_r.s2.rmode) begin
        if ((asm_if.cnt == CNT_CHAR7) & ~rch[LEVEL7_BIT]) begin
          st_nxt.clutch = 1'b0;
          st_nxt.tape_end_flag = 1'b1;
        end else begin
          st_nxt.input_assembly_register[CHAR_W*int'(aidx) +: CHAR_W] =
            rch[CHAR_W-1:0];
          asm_if.adv = 1'b1;
          if (asm_if.cnt == CNT_CHAR0) begin
            st_nxt.in_ready = 1'b1;
          end
        end
      end else begin
        st_nxt.input_assembly_register = '0;
        st_nxt.input_assembly_register[TAPE_W-1:0] =
          st_r.eight_level ? rch : {1'b0, rch[TAPE_W-2:0]};
        st_nxt.in_ready = 1'b1;
      end
    end

    // keyboard entry
    if (kbd_rise & st_r.keyboard_selected_flag & st_r.in_active & ~st_r.in_ready) begin
      st_nxt.input_assembly_register = {{(WORD_W-KBD_W){1'b0}}, st_r.s2.kchar};
      st_nxt.in_ready = 1'b1;
    end

    // idle input side
    if (~(st_r.reader_selected_flag | st_r.keyboard_selected_flag) | ~st_r.in_active) begin
      st_nxt.input_assembly_register = '0;
      st_nxt.in_ready = 1'b0;
    end

    // output distributor
    if (tim_rise & st_r.out_ready & st_r.out_active &
        ((st_r.punch_selected_flag & st_r.punch_motor_flag) | st_r.printer_selected_flag)) begin
      if (st_r.six_bit_packing_flag) begin
        st_nxt.out_char = {2'h0,
          st_r.output_word_register[CHAR_W*int'(didx) +: CHAR_W]};
        dis_if.adv = 1'b1;
      end else if (st_r.punch_selected_flag) begin
        st_nxt.out_char = st_r.output_word_register[TAPE_W-1:0];
      end else begin
        st_nxt.out_char = {2'h0, st_r.output_word_register[KBD_W-1:0]};
      end
      st_nxt.punch_stb = st_r.punch_selected_flag;
      st_nxt.print_stb = st_r.printer_selected_flag;
      if (~st_r.six_bit_packing_flag | (dis_if.cnt == CNT_CHAR0)) begin
        st_nxt.out_ready = 1'b0;
      end
    end
    if (bus_acc & avs_write_in & (avs_address_in == OFS_OUT_LO)) begin
      st_nxt.output_word_register[31:0] =
        (st_r.output_word_register[31:0] & ~be_mask('1, avs_byteenable_in)) |
        be_mask(avs_writedata_in, avs_byteenable_in);
    end
    if (bus_acc & avs_write_in & (avs_address_in == OFS_OUT_HI)) begin
      st_nxt.output_word_register[47:32] =
        (st_r.output_word_register[47:32] & ~lane_m[15:0]) |
        (avs_writedata_in[15:0] & lane_m[15:0]);
      st_nxt.out_ready = 1'b1;
    end
    if (~st_r.out_active) begin
      st_nxt.out_ready = 1'b0;
    end

    // external master clear
    if (st_r.s2.mclr) begin
      st_nxt.reader_selected_flag = 1'b1;
      st_nxt.keyboard_selected_flag = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= '0;
      st_r.reader_selected_flag <= RST_SEL_RDR;
      st_r.wreq <= RST_WREQ;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = st_r.wreq;
  assign reader_clutch_out = st_r.clutch;
  assign reader_motor_out = st_r.reader_motor_flag;
  assign out_char_out = st_r.out_char;
  assign punch_strobe_out = st_r.punch_stb;
  assign print_strobe_out = st_r.print_stb;
  assign punch_motor_out = st_r.punch_motor_flag;

endmodule : ccio_top

// *** verification/ccio_units.sv ***
`timescale 1ns/10ps
module ccio_units (
  // clock and reader state
  input wire logic clk_in,
  input wire logic reader_clutch_in,
  // unit lines
  output logic [7:0] rdr_char_out = 8'h00,
  output logic rdr_feed_out = 1'b0,
  output logic [5:0] kbd_char_out = 6'h00,
  output logic kbd_strobe_out = 1'b0,
  output logic out_timing_out = 1'b0
);
  // k: 0 reader frame, 1 key, 2 output timing; gap sets the pace
  task automatic strike(input int k, input logic [7:0] ch, input int gap);
    int n;
    n = 0;
    @(posedge clk_in);
    while (k == 0 && reader_clutch_in !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk_in);
    end
    if (k == 0) rdr_char_out <= ch;
    if (k == 1) kbd_char_out <= ch[5:0];
    repeat (2) @(posedge clk_in);
    if (k == 0) rdr_feed_out <= 1'b1;
    if (k == 1) kbd_strobe_out <= 1'b1;
    if (k == 2) out_timing_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    rdr_feed_out <= 1'b0;
    kbd_strobe_out <= 1'b0;
    out_timing_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    // released lines stop showing the last value
    rdr_char_out <= ~rdr_char_out;
    kbd_char_out <= ~kbd_char_out;
  endtask : strike
endmodule : ccio_units

// *** verification/ccio_top_assertions.sv ***
`timescale 1ns/10ps
module ccio_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // bus and output side
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [7:0] out_char_out,
  input wire logic punch_strobe_out,
  input wire logic print_strobe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("late bus answer");
  property p_wait_short;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("answer too long");
  property p_wait_cause;
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rd_hold;
    !avs_waitrequest_out |=> $stable(avs_readdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rst;
    disable iff (1'b0) srst_in |=> avs_waitrequest_out && avs_readdata_out == 32'h0
      && out_char_out == 8'h00 && !punch_strobe_out && !print_strobe_out;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_strobe_pulse;
    punch_strobe_out || print_strobe_out |=> !punch_strobe_out && !print_strobe_out;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_ch2_excl;
    !(punch_strobe_out && print_strobe_out);
  endproperty
  a_ch2_excl: assert property (p_ch2_excl) else $error("two output units at once");
  property p_char_hold;
    !punch_strobe_out && !print_strobe_out |-> $stable(out_char_out);
  endproperty
  a_char_hold: assert property (p_char_hold) else $error("char moved");
endmodule : ccio_chk
bind ccio_top ccio_chk chk_i (.clk_in, .srst_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .out_char_out, .punch_strobe_out, .print_strobe_out);

// *** verification/console_char_io_distributor_tb.sv ***
`timescale 1ns/10ps
module console_char_io_distributor_tb;
  import ccio_pkg::*;
  logic clk_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdv, seed = 32'h37;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic reader_mode_sw_in = 1'b1, reader_motor_sw_in = 1'b1, ext_master_clear_in = 1'b0;
  logic kbd_cr_tab_in = 1'b0, kbd_upper_case_in = 1'b0, punch_out_of_tape_in = 1'b0;
  logic avs_waitrequest_out, rdr_feed_in, kbd_strobe_in, out_timing_in, reader_clutch_out;
  logic reader_motor_out, punch_strobe_out, print_strobe_out, punch_motor_out;
  logic [7:0] rdr_char_in, out_char_out;
  logic [5:0] kbd_char_in;
  logic [8:0] fl = 9'h001, x;
  logic [63:0] w, v;
  logic [8:0] q [$];
  logic [14:0] codes [10] = '{15'h1240, 15'h1260, 15'h1280, 15'h1288, 15'h1290,
    15'h2240, 15'h2248, 15'h2280, 15'h2288, 15'h22a0};
  logic [14:0] sns [5] = '{SNS_KBD_CR, SNS_KBD_CASE, SNS_RDR_EOT, SNS_RDR_MODE, SNS_PUN_OUT};
  int num_checks = 0, n_mismatch = 0, i, k, n;
  always #2.5 clk_in = ~clk_in;
  ccio_top dut (.*);
  ccio_units u (.clk_in(clk_in), .reader_clutch_in(reader_clutch_out),
    .rdr_char_out(rdr_char_in), .rdr_feed_out(rdr_feed_in), .kbd_char_out(kbd_char_in),
    .kbd_strobe_out(kbd_strobe_in), .out_timing_out(out_timing_in));
  always @(posedge clk_in) if (punch_strobe_out === 1'b1 || print_strobe_out === 1'b1)
    q.push_back({print_strobe_out, out_char_out});
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic hang();
    n_mismatch++;
    conclude();
  endtask : hang
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int c;
    c = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
      if (c++ > 50) hang();
    end while (avs_waitrequest_out !== 1'b0);
    rdv = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic st();
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rdv[9:0], {1'b1, fl});
    chk({reader_motor_out, punch_motor_out}, {1'b1, fl[ST_PUN_MOT]});
  endtask : st
  task automatic sel(input logic [14:0] c);
    logic [2:0] d;
    logic t;
    d = c[5:3];
    t = (c[11:6] == EQ_TAPE);
    fl[ST_TAPE_END] = (c[14:12] == CH_IN) && t && (d == D1_EOT_SET);
    if (c[14:12] == CH_IN) begin
      fl[ST_SEL_RDR] = t;
      fl[ST_SEL_KBD] = !t;
      if (!t) fl[ST_CR_IRQ] = (d == D1_CR_IRQ);
      if (t && d != D1_EOT_SET) fl[ST_EOT_IRQ] = (d == D1_ZERO);
    end else if (!t || d <= D1_MOTOR_MAX) begin
      fl[ST_SEL_PUN] = t;
      fl[ST_SEL_PRT] = !t;
      fl[ST_PACK] = (d == D1_ZERO);
      fl[ST_PUN_MOT] = fl[ST_PUN_MOT] | t;
    end else fl[ST_PUN_MOT] = 1'b0;
    bus(1'b1, OFS_FUNC, {17'h0, c});
    st();
  endtask : sel
  task automatic rword(input logic [47:0] e);
    logic [31:0] lo;
    int c;
    c = 0;
    rdv = 32'h0;
    while (rdv[ST_IN_RDY] !== 1'b1) begin
      if (c++ > 40) hang();
      bus(1'b0, OFS_STATUS, 32'h0);
    end
    bus(1'b0, OFS_IN_LO, 32'h0);
    lo = rdv;
    bus(1'b0, OFS_IN_HI, 32'h0);
    chk({rdv[15:0], lo}, e);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rdv[ST_IN_RDY], 1'b0);
  endtask : rword
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    st();
    for (i = 0; i < 20; i++) sel(codes[i < 10 ? i : rnd() % 10]);
    for (i = 0; i < 10; i++) begin
      v = rnd();
      {punch_out_of_tape_in, reader_mode_sw_in, kbd_upper_case_in, kbd_cr_tab_in} <= v[3:0];
      repeat (3) @(posedge clk_in);
      bus(1'b1, OFS_SENSE, {17'h0, sns[i % 5][14:1], v[4]});
      bus(1'b0, OFS_SENSE, 32'h0);
      x = {4'h0, v[3], v[2], fl[ST_TAPE_END], !v[1], v[0]};
      chk(rdv[0], x[i % 5]);
    end
    // assembly read, then a missing level seven at word start
    reader_mode_sw_in <= 1'b1;
    sel(codes[4]);
    bus(1'b1, OFS_BUF, 32'h1);
    w = 64'h0;
    for (i = 0; i < 8; i++) begin
      v = rnd();
      v[LEVEL7_BIT] = v[LEVEL7_BIT] | (i == 0);
      u.strike(0, v[7:0], 1 + rnd() % 20);
      w = {w[57:0], v[5:0]};
    end
    rword(w[47:0]);
    u.strike(0, 8'h00, 2);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({rdv[ST_CLUTCH], rdv[ST_TAPE_END]}, 2'b01);
    bus(1'b1, OFS_BUF, 32'h0);
    reader_mode_sw_in <= 1'b0;
    sel(codes[4]);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, OFS_BUF, {29'h0, i[0], 2'b01});
      v = rnd();
      u.strike(0, v[7:0], 3);
      rword({40'h0, i[0] & v[7], v[6:0]});
      bus(1'b1, OFS_BUF, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rdv[ST_CLUTCH], 1'b0);
    end
    sel(codes[0]);
    bus(1'b1, OFS_BUF, 32'h1);
    v = rnd();
    u.strike(1, v[7:0], 3);
    rword({42'h0, v[5:0]});
    bus(1'b1, OFS_BUF, 32'h0);
    // punch assembly, printer character, punch character
    for (k = 0; k < 3; k++) begin
      sel(codes[k == 1 ? 6 : 7 + k / 2]);
      w = {rnd(), rnd()};
      bus(1'b1, OFS_BUF, 32'h2);
      bus(1'b1, OFS_OUT_LO, w[31:0]);
      bus(1'b1, OFS_OUT_HI, {16'h0, w[47:32]});
      for (i = 0; i < (k == 0 ? 8 : 1); i++) begin
        u.strike(2, 8'h00, 1 + rnd() % 20);
        for (n = 0; n < 40 && q.size() == 0; n++) @(posedge clk_in);
        if (q.size() == 0) hang();
        x = k == 1 ? {3'b100, w[5:0]} : {1'b0, w[7:0]};
        if (k == 0) x = {3'b000, 6'(w >> (42 - 6 * i))};
        chk(q.pop_front(), x);
      end
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rdv[ST_OUT_RDY], 1'b0);
      bus(1'b1, OFS_BUF, 32'h0);
    end
    sel(codes[0]);
    ext_master_clear_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext_master_clear_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    fl[ST_SEL_RDR] = 1'b1;
    fl[ST_SEL_KBD] = 1'b0;
    st();
    conclude();
  end
endmodule : console_char_io_distributor_tb
